// ---- logic/ubrg_top.sv ----
// Dedicated baud rate generator of an asynchronous serial port, with its
// control registers on a classic Wishbone slave.
// Assumes one clock mclk, a synchronous reset, and that the serial
// receive line and the timer output arrive asynchronously.
//
// The placing of the registers and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "ubrg_regs.svh"

module ubrg_top #(
	parameter int CW = 5,
	parameter logic [4:0] FRAME_BITS = `UBRG_FRAME_BITS
) (
	input wire logic mclk,
	input wire logic rst,
	input wire ubrg_pkg::ubrg_wb_req_s wb_req,
	output ubrg_pkg::ubrg_wb_rsp_s wb_rsp,
	input wire logic serial_rx_line,
	input wire logic timer_output_source,
	output ubrg_pkg::ubrg_clk_out_s clk_out
);
	import ubrg_pkg::*;

	typedef enum logic [1:0] {
		UBRG_RX_IDLE,
		UBRG_RX_HUNT,
		UBRG_RX_FRAME
	} ubrg_rx_state_e;

	logic [7:0] baud_generator_control;
	logic [7:0] serial_operation_mode_reg;
	logic serial_power_bit;
	logic tx_enable_bit;
	logic rx_enable_bit;
	ubrg_src_e clk_sel;
	logic [CW-1:0] divisor_k_field;

	logic bus_req;
	logic wr_strobe;
	logic [CW-1:0] next_k;
	logic [31:0] next_rd;

	logic base_clk;
	logic base_tick;

	logic tx_run;
	logic tx_first_pending;
	logic tx_restart;
	logic [CW-1:0] tx_count;
	logic tx_serial_clk;

	logic rx_run;
	logic rx_restart;
	logic [CW-1:0] rx_count;
	logic rx_serial_clk;
	logic rx_half;

	logic rx_meta;
	logic rx_sync;
	logic rx_prev;
	logic rx_fall;

	ubrg_rx_state_e rx_state;
	ubrg_rx_state_e next_rx_state;
	logic [5:0] rx_halves;
	logic [5:0] frame_halves;
	logic rx_sample;
	logic next_rx_sample;

	assign serial_power_bit = serial_operation_mode_reg[`UBRG_MODE_POWER];
	assign tx_enable_bit = serial_operation_mode_reg[`UBRG_MODE_TX_EN];
	assign rx_enable_bit = serial_operation_mode_reg[`UBRG_MODE_RX_EN];
	assign clk_sel = ubrg_src_e'(baud_generator_control[
		`UBRG_BAUD_SEL_HI:`UBRG_BAUD_SEL_LO]);
	assign divisor_k_field = baud_generator_control[
		`UBRG_BAUD_K_HI:`UBRG_BAUD_K_LO];

	// Wishbone slave: one wait state, ack for one cycle per request.
	assign bus_req = wb_req.cyc && wb_req.stb && !wb_rsp.ack;
	assign wr_strobe = bus_req && wb_req.we && wb_req.sel[0];

	// A divisor below the minimum would give a bit rate the receive
	// start check cannot follow, so it is raised to the minimum.
	always_comb begin
		next_k = wb_req.dat[`UBRG_BAUD_K_HI:`UBRG_BAUD_K_LO];
		if (next_k < `UBRG_K_MIN) begin
			next_k = `UBRG_K_MIN;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			baud_generator_control <= `UBRG_BAUD_CTRL_RESET;
		end else if (wr_strobe && wb_req.adr == `UBRG_OFS_BAUD_CTRL) begin
			baud_generator_control <= {wb_req.dat[7:5], next_k};
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			serial_operation_mode_reg <= `UBRG_MODE_RESET;
		end else if (wr_strobe && wb_req.adr == `UBRG_OFS_MODE) begin
			serial_operation_mode_reg <= {wb_req.dat[7:5], 5'h00};
		end
	end

	always_comb begin
		next_rd = 32'h0000_0000;
		case (wb_req.adr)
			`UBRG_OFS_BAUD_CTRL: begin
				next_rd = {24'h00_0000, baud_generator_control};
			end
			`UBRG_OFS_MODE: begin
				next_rd = {24'h00_0000, serial_operation_mode_reg};
			end
			`UBRG_OFS_STATUS: begin
				next_rd = {16'h0000, tx_first_pending,
					rx_state == UBRG_RX_FRAME, rx_state == UBRG_RX_HUNT,
					tx_run, 2'h0, rx_serial_clk, tx_serial_clk,
					3'h0, rx_count};
				next_rd[20:16] = tx_count;
			end
			default: begin
				next_rd = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			wb_rsp.ack <= 1'b0;
		end else begin
			wb_rsp.ack <= bus_req;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			wb_rsp.dat <= 32'h0000_0000;
		end else if (bus_req && !wb_req.we) begin
			wb_rsp.dat <= next_rd;
		end
	end

	// Base clock selection and power gating.
	ubrg_prescaler u_prescaler (
		.mclk(mclk),
		.rst(rst),
		.power(serial_power_bit),
		.src(clk_sel),
		.timer_output_source(timer_output_source),
		.base_clk(base_clk),
		.base_tick(base_tick)
	);

	// Transmit side.
	assign tx_run = serial_power_bit && tx_enable_bit;
	assign tx_restart = wr_strobe && wb_req.adr == `UBRG_OFS_TX_SHIFT &&
		tx_first_pending;

	// Only the first data write after enabling realigns the bit clock;
	// later writes must not disturb a frame already running.
	always_ff @(posedge mclk) begin
		if (rst || !tx_run) begin
			tx_first_pending <= 1'b1;
		end else if (tx_restart) begin
			tx_first_pending <= 1'b0;
		end
	end

	ubrg_half_counter #(
		.CW(CW)
	) u_tx_counter (
		.mclk(mclk),
		.rst(rst),
		.run(tx_run),
		.restart(tx_restart),
		.base_tick(base_tick),
		.k(divisor_k_field),
		.count(tx_count),
		.serial_clk(tx_serial_clk),
		.half_pulse()
	);

	// Receive line synchroniser; the first flop feeds only the second.
	always_ff @(posedge mclk) begin
		rx_meta <= serial_rx_line;
		rx_sync <= rx_meta;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			rx_prev <= 1'b1;
		end else begin
			rx_prev <= rx_sync;
		end
	end

	assign rx_fall = rx_prev && !rx_sync;

	// Receive sequencing: idle, start bit check, frame in progress.
	assign frame_halves = {FRAME_BITS, 1'b0} - 6'h01;

	always_comb begin
		next_rx_state = rx_state;
		next_rx_sample = 1'b0;
		case (rx_state)
			UBRG_RX_IDLE: begin
				if (rx_fall) begin
					next_rx_state = UBRG_RX_HUNT;
				end
			end
			UBRG_RX_HUNT: begin
				if (rx_half) begin
					next_rx_sample = 1'b1;
					next_rx_state = rx_sync ? UBRG_RX_IDLE :
						UBRG_RX_FRAME;
				end
			end
			UBRG_RX_FRAME: begin
				if (rx_half && rx_halves[0]) begin
					next_rx_sample = 1'b1;
				end
				if (rx_half && rx_halves == frame_halves) begin
					next_rx_state = UBRG_RX_IDLE;
				end
			end
			default: begin
				next_rx_state = UBRG_RX_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst || !rx_enable_bit || !serial_power_bit) begin
			rx_state <= UBRG_RX_IDLE;
		end else begin
			rx_state <= next_rx_state;
		end
	end

	// Half bits counted since the start bit was confirmed at its middle.
	always_ff @(posedge mclk) begin
		if (rst || rx_state != UBRG_RX_FRAME) begin
			rx_halves <= 6'h01;
		end else if (rx_half) begin
			rx_halves <= rx_halves + 6'h01;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst || !rx_run) begin
			rx_sample <= 1'b0;
		end else begin
			rx_sample <= next_rx_sample;
		end
	end

	assign rx_run = serial_power_bit && rx_enable_bit &&
		rx_state != UBRG_RX_IDLE;
	assign rx_restart = 1'b0;

	ubrg_half_counter #(
		.CW(CW)
	) u_rx_counter (
		.mclk(mclk),
		.rst(rst),
		.run(rx_run),
		.restart(rx_restart),
		.base_tick(base_tick),
		.k(divisor_k_field),
		.count(rx_count),
		.serial_clk(rx_serial_clk),
		.half_pulse(rx_half)
	);

	// Outputs are registered so that the pins never see decode glitches.
	always_ff @(posedge mclk) begin
		if (rst) begin
			clk_out <= '0;
		end else begin
			clk_out.base_clk <= base_clk;
			clk_out.tx_clk <= tx_serial_clk;
			clk_out.rx_clk <= rx_serial_clk;
			clk_out.rx_sample <= rx_sample;
			clk_out.rx_active <= rx_state == UBRG_RX_FRAME;
		end
	end

endmodule

// ---- logic/ubrg_regs.svh ----
// Register offsets, field positions, reset values and limits of the
// baud rate generator. Included by every design file that needs them.
`ifndef UBRG_REGS_SVH
`define UBRG_REGS_SVH

`define UBRG_ADDR_W 4
`define UBRG_OFS_BAUD_CTRL 4'h0
`define UBRG_OFS_MODE 4'h4
`define UBRG_OFS_TX_SHIFT 4'h8
`define UBRG_OFS_STATUS 4'hc

`define UBRG_BAUD_SEL_HI 7
`define UBRG_BAUD_SEL_LO 6
`define UBRG_BAUD_K_HI 4
`define UBRG_BAUD_K_LO 0
`define UBRG_BAUD_CTRL_RESET 8'h08

`define UBRG_MODE_POWER 7
`define UBRG_MODE_TX_EN 6
`define UBRG_MODE_RX_EN 5
`define UBRG_MODE_RESET 8'h00

`define UBRG_K_MIN 5'h08
`define UBRG_K_MAX 5'h1f

`define UBRG_PRE_DIV2_BIT 0
`define UBRG_PRE_DIV8_BIT 2
`define UBRG_PRE_DIV32_BIT 4

`define UBRG_FRAME_BITS 5'h0a

`endif

// ---- logic/ubrg_pkg.sv ----
// Types shared by the baud rate generator files.
// Assumes nothing of its surroundings.
package ubrg_pkg;

	typedef enum logic [1:0] {
		UBRG_SRC_TIMER,
		UBRG_SRC_DIV2,
		UBRG_SRC_DIV8,
		UBRG_SRC_DIV32
	} ubrg_src_e;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} ubrg_wb_req_s;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} ubrg_wb_rsp_s;

	typedef struct packed {
		logic base_clk;
		logic tx_clk;
		logic rx_clk;
		logic rx_sample;
		logic rx_active;
	} ubrg_clk_out_s;

endpackage

// ---- logic/ubrg_prescaler.sv ----
// Source clock selector: turns mclk or the timer output into a base clock
// level and a one-cycle tick per base period, at the rise for the timer and divide-by-2, a cycle before it for divide-by-8 and 32.
// Assumes the timer output is asynchronous to mclk.
`timescale 1ns/1ps
`include "ubrg_regs.svh"

module ubrg_prescaler (
	input wire logic mclk,
	input wire logic rst,
	input wire logic power,
	input wire ubrg_pkg::ubrg_src_e src,
	input wire logic timer_output_source,
	output logic base_clk,
	output logic base_tick
);
	import ubrg_pkg::*;

	logic [4:0] div_cnt;
	logic tmr_meta;
	logic tmr_sync;
	logic tmr_prev;
	logic next_level;
	logic next_tick;

	always_ff @(posedge mclk) begin
		tmr_meta <= timer_output_source;
		tmr_sync <= tmr_meta;
		tmr_prev <= tmr_sync;
	end

	// Stopping the divider while unpowered keeps the first base period whole.
	always_ff @(posedge mclk) begin
		if (rst || !power) begin
			div_cnt <= 5'h00;
		end else begin
			div_cnt <= div_cnt + 5'h01;
		end
	end

	always_comb begin
		next_level = 1'b0;
		next_tick = 1'b0;
		case (src)
			UBRG_SRC_TIMER: begin
				next_level = tmr_sync;
				next_tick = tmr_sync && !tmr_prev;
			end
			UBRG_SRC_DIV2: begin
				next_level = div_cnt[`UBRG_PRE_DIV2_BIT];
				next_tick = div_cnt[`UBRG_PRE_DIV2_BIT:0] == 1'h1;
			end
			UBRG_SRC_DIV8: begin
				next_level = div_cnt[`UBRG_PRE_DIV8_BIT];
				next_tick = div_cnt[`UBRG_PRE_DIV8_BIT:0] == 3'h3;
			end
			UBRG_SRC_DIV32: begin
				next_level = div_cnt[`UBRG_PRE_DIV32_BIT];
				next_tick = div_cnt[`UBRG_PRE_DIV32_BIT:0] == 5'h0f;
			end
			default: begin
				next_level = 1'b0;
				next_tick = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst || !power) begin
			base_clk <= 1'b0;
			base_tick <= 1'b0;
		end else begin
			base_clk <= next_level;
			base_tick <= next_tick;
		end
	end

endmodule

// ---- logic/ubrg_half_counter.sv ----
// One 5-bit programmable counter: counts k base ticks per half bit and
// toggles its serial clock at each half, so a bit spans 2k base ticks.
// Assumes base_tick is a one-cycle pulse on mclk.
`timescale 1ns/1ps
`include "ubrg_regs.svh"

module ubrg_half_counter #(
	parameter int CW = 5
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic run,
	input wire logic restart,
	input wire logic base_tick,
	input wire logic [CW-1:0] k,
	output logic [CW-1:0] count,
	output logic serial_clk,
	output logic half_pulse
);
	import ubrg_pkg::*;

	logic at_top;

	assign at_top = count == CW'(k - CW'(1));

	always_ff @(posedge mclk) begin
		if (rst || !run || restart) begin
			count <= '0;
		end else if (base_tick) begin
			count <= at_top ? '0 : count + CW'(1);
		end
	end

	always_ff @(posedge mclk) begin
		if (rst || !run || restart) begin
			serial_clk <= 1'b0;
		end else if (base_tick && at_top) begin
			serial_clk <= !serial_clk;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst || !run || restart) begin
			half_pulse <= 1'b0;
		end else begin
			half_pulse <= base_tick && at_top;
		end
	end

endmodule

// ---- testbench/ubrg_top_monitor.sv ----
// Port checker of the baud rate generator, bound into ubrg_top.
// Assumes the bench runs the timer source with a period of TPER cycles.
`timescale 1ns/1ps
module ubrg_top_monitor #(
	parameter int CW = 5,
	parameter logic [4:0] FRAME_BITS = 5'h0a
) (
	input wire logic mclk,
	input wire logic rst,
	input wire ubrg_pkg::ubrg_wb_req_s wb_req,
	input wire ubrg_pkg::ubrg_wb_rsp_s wb_rsp,
	input wire logic serial_rx_line,
	input wire logic timer_output_source,
	input wire ubrg_pkg::ubrg_clk_out_s clk_out
);
	import ubrg_pkg::*;
	// Shared with the bench; an irregular timer would void the rate check.
	localparam int TPER = 6;
	logic [7:0] ctl, mode;
	logic tseen;
	int per, tgap, acnt;
	wire wr = wb_rsp.ack && wb_req.we && wb_req.sel[0];
	wire txon = mode[7] && mode[6];
	wire rxon = mode[7] && mode[5];
	always_comb per = ctl[4:0] * (ctl[7:6] == 2'h0 ? TPER :
		ctl[7:6] == 2'h1 ? 2 : ctl[7:6] == 2'h2 ? 8 : 32);
	always_ff @(posedge mclk) begin
		if (rst) begin
			ctl <= 8'h08;
			mode <= 8'h00;
		end else if (wr && wb_req.adr == 4'h0) begin
			ctl <= {wb_req.dat[7:5], (wb_req.dat[4:0] < 5'h08) ? 5'h08 :
				wb_req.dat[4:0]};
		end else if (wr && wb_req.adr == 4'h4) begin
			mode <= wb_req.dat[7:0];
		end
	end
	always_ff @(posedge mclk) begin
		tgap <= $changed(clk_out.tx_clk) ? 0 : tgap + 1;
		acnt <= clk_out.rx_active ? acnt + 1 : 0;
	end
	always_ff @(posedge mclk) begin
		if (rst || !txon || (wb_rsp.ack && wb_req.we)) begin
			tseen <= 1'b0;
		// The first rise after a clear ends a half of unknown prescaler
		// phase, so only halves that begin at or after that rise are measured.
		end else if ($rose(clk_out.tx_clk)) begin
			tseen <= 1'b1;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	chk_ack_next: assert property (
		wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack)
		else $error("request not answered in one cycle");
	chk_ack_pulse: assert property (
		wb_rsp.ack |=> !wb_rsp.ack) else $error("ack longer than one cycle");
	chk_base_low: assert property (
		(!mode[7]) [*4] |-> !clk_out.base_clk)
		else $error("base clock runs with power off");
	chk_tx_stop: assert property (
		(!txon) [*4] |-> !clk_out.tx_clk) else $error("tx clock while off");
	chk_rx_stop: assert property (
		(!rxon) [*4] |-> !clk_out.rx_active && !clk_out.rx_clk)
		else $error("rx timing while off");
	chk_tx_rate: assert property (
		$changed(clk_out.tx_clk) && tseen |-> tgap == per - 1)
		else $error("tx half bit length wrong");
	chk_rx_pulse: assert property (
		clk_out.rx_sample |=> !clk_out.rx_sample)
		else $error("rx sample pulse too long");
	chk_rx_frame: assert property (
		$fell(clk_out.rx_active) && rxon |->
		acnt == (2 * FRAME_BITS - 1) * per)
		else $error("rx frame length wrong");
	chk_rx_begin: assert property (
		$rose(clk_out.rx_active) |->
		clk_out.rx_sample || $past(clk_out.rx_sample))
		else $error("rx frame began without a start check");
	cov_tx_half: cover property ($changed(clk_out.tx_clk) && tseen);
	cov_rx_frame: cover property ($fell(clk_out.rx_active) && rxon);
	cov_rx_check: cover property (clk_out.rx_sample && !clk_out.rx_active);
endmodule

bind ubrg_top ubrg_top_monitor #(.CW(CW), .FRAME_BITS(FRAME_BITS)) mon_u (
	.mclk(mclk),
	.rst(rst),
	.wb_req(wb_req),
	.wb_rsp(wb_rsp),
	.serial_rx_line(serial_rx_line),
	.timer_output_source(timer_output_source),
	.clk_out(clk_out)
);

// ---- testbench/ubrg_rx_partner.sv ----
// Remote serial transmitter driving the receive line, idle high.
// Assumes one request at a time from the bench, go held for one cycle.
`timescale 1ns/1ps
module ubrg_rx_partner (
	input wire logic mclk,
	input wire logic go,
	input wire logic glitch,
	input wire logic [7:0] data,
	input wire logic [15:0] bit_len,
	output logic line,
	output logic busy
);
	logic [9:0] frame;
	initial begin
		line = 1'b1;
		busy = 1'b0;
		forever begin
			@(posedge mclk);
			if (go) begin
				busy <= 1'b1;
				// A glitch is a two-cycle low, far shorter than k ticks.
				frame = glitch ? 10'h3fe : {1'b1, data, 1'b0};
				for (int i = 0; i < 10; i++) begin
					line <= frame[i];
					// Exact bit length keeps the rate error at zero.
					repeat (glitch ? 16'h2 : bit_len) @(posedge mclk);
				end
				busy <= 1'b0;
			end
		end
	end
endmodule

// ---- testbench/ubrg_top_tb.sv ----
// Self-checking bench of the baud rate generator.
// Assumes the checker is bound in and the partner drives the rx line.
`timescale 1ns/1ps
module ubrg_top_tb;
	import ubrg_pkg::*;
	localparam logic [4:0] FB = 5'h0a;
	logic mclk, rst, rx, tmr, go, glitch, busy;
	logic [7:0] rxd;
	logic [15:0] bit_len;
	logic [31:0] rd;
	int failures, checks_done, n, a, p, k, s;
	ubrg_wb_req_s req;
	ubrg_wb_rsp_s rsp;
	ubrg_clk_out_s co;
	ubrg_top #(.CW(5), .FRAME_BITS(FB)) dut_u (.mclk(mclk), .rst(rst),
		.wb_req(req), .wb_rsp(rsp), .serial_rx_line(rx),
		.timer_output_source(tmr), .clk_out(co));
	ubrg_rx_partner part_u (.mclk(mclk), .go(go), .glitch(glitch),
		.data(rxd), .bit_len(bit_len), .line(rx), .busy(busy));
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	// The timer source runs with a six-cycle period, as the checker expects.
	initial begin
		tmr = 1'b0;
		forever begin
			repeat (3) @(posedge mclk);
			tmr <= ~tmr;
		end
	end
	function automatic int dv(int s);
		return s == 0 ? 6 : s == 1 ? 2 : s == 2 ? 8 : 32;
	endfunction
	task automatic close_out();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic we, input logic [3:0] ad,
		input logic [7:0] d, input logic [3:0] sl);
		req <= '{1'b1, 1'b1, we, ad, sl, {24'h0, d}};
		@(posedge mclk);
		while (rsp.ack !== 1'b1) @(posedge mclk);
		rd = rsp.dat;
		req <= '0;
		@(posedge mclk);
	endtask
	task automatic gap(input int w, output int c);
		logic v;
		v = w ? co.rx_active : w == 0 ? co.tx_clk : 1'b0;
		v = (w == 2) ? co.base_clk : v;
		do @(posedge mclk); while ((w == 1 ? co.rx_active : w == 2 ?
			co.base_clk : co.tx_clk) === v);
		v = ~v;
		c = 0;
		do begin
			@(posedge mclk);
			c++;
		end while ((w == 1 ? co.rx_active : w == 2 ? co.base_clk :
			co.tx_clk) === v);
	endtask
	task automatic send(input logic g);
		go <= 1'b1;
		glitch <= g;
		rxd <= 8'($urandom);
		@(posedge mclk);
		go <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic poll(output int ac, output int ps);
		ac = 0;
		ps = 0;
		repeat (100) begin
			@(posedge mclk);
			ac += (co.rx_active !== 1'b0);
			ps += (co.rx_sample === 1'b1);
		end
	endtask
	initial begin
		repeat (60000) @(posedge mclk);
		failures++;
		close_out();
	end
	initial begin
		req = '0;
		rst = 1'b1;
		go = 1'b0;
		glitch = 1'b0;
		rxd = 8'h00;
		bit_len = 16'h10;
		failures = 0;
		checks_done = 0;
		n = $urandom(3252);
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		wb(1'b0, 4'h0, 8'h00, 4'hf);
		check(rd, 32'h08);
		wb(1'b0, 4'h4, 8'h00, 4'hf);
		check(rd, 32'h00);
		wb(1'b0, 4'h2, 8'h00, 4'hf);
		check(rd, 32'h00);
		wb(1'b1, 4'h0, 8'h43, 4'h1);
		wb(1'b1, 4'h0, 8'hff, 4'he);
		wb(1'b0, 4'h0, 8'h00, 4'hf);
		check(rd, 32'h48);
		for (s = 0; s < 4; s++) begin
			k = s == 1 ? 8 : s == 2 ? 31 : $urandom_range(31, 8);
			wb(1'b1, 4'h0, {s[1:0], 1'b0, k[4:0]}, 4'h1);
			wb(1'b1, 4'h4, 8'hc0, 4'h1);
			gap(2, n);
			check(n, dv(s) / 2);
			gap(0, n);
			wb(1'b1, 4'h8, 8'h55, 4'h1);
			check(co.tx_clk, 1'b0);
			while (co.tx_clk !== 1'b1) @(posedge mclk);
			gap(0, n);
			check(n, dv(s) * k);
			wb(1'b1, 4'h4, 8'h80, 4'h1);
			repeat (8) @(posedge mclk);
			check(co.tx_clk, 1'b0);
			wb(1'b1, 4'h4, 8'h00, 4'h1);
			repeat (8) @(posedge mclk);
			check(co.base_clk, 1'b0);
		end
		k = $urandom_range(31, 8);
		bit_len = 16'(4 * k);
		wb(1'b1, 4'h0, {3'b010, k[4:0]}, 4'h1);
		wb(1'b1, 4'h4, 8'ha0, 4'h1);
		for (s = 0; s < 2; s++) begin
			while (busy !== 1'b0) @(posedge mclk);
			send(1'b0);
			gap(1, n);
			check(n, (2 * FB - 1) * 2 * k);
		end
		while (busy !== 1'b0) @(posedge mclk);
		wb(1'b0, 4'hc, 8'h00, 4'hf);
		check(rd[4:0], 5'h00);
		send(1'b1);
		poll(a, p);
		check(a, 0);
		check(p, 1);
		wb(1'b1, 4'h4, 8'h80, 4'h1);
		send(1'b0);
		poll(a, p);
		check(a + p, 0);
		close_out();
	end
endmodule
